//--- tpm_defines.svh
// Register offsets, field positions, reset values and timing counts of the motor PWM.
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TPM_ADDR_W 8
`define TPM_DATA_W 32
`define TPM_OFS_CTRL 8'h00
`define TPM_OFS_PERIOD 8'h04
`define TPM_OFS_DUTY0 8'h08
`define TPM_OFS_DEAD 8'h20
`define TPM_OFS_STATUS 8'h24
`define TPM_OFS_COUNT 8'h28
`define TPM_OFS_TRIG0 8'h2c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TPM_CTRL_RUN 0
`define TPM_CTRL_UPDOWN 1
`define TPM_CTRL_MOTOR 2
`define TPM_CTRL_MMODE_LO 3
`define TPM_CTRL_MMODE_HI 4
`define TPM_CTRL_OLS_LO 8
`define TPM_CTRL_OLS_HI 13
`define TPM_DEAD_CNT_HI 7
`define TPM_DEAD_PRESC 8
`define TPM_DEAD_EN 15
`define TPM_ST_BOTTOM 6
`define TPM_ST_PERIOD 7
`define TPM_ST_DOWN 15
`define TPM_TRIG_SEL_LO 16
`define TPM_TRIG_SEL_HI 17

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define TPM_OLS_RESET 6'h38
`define TPM_PERIOD_RESET 16'hffff
`define TPM_DT_SCALE_SLOW 4
`define TPM_DT_SCALE_FAST 2
`define TPM_DT_CYC_W 12

`endif

//--- tpm_pkg.sv
// Types shared by the motor PWM block.
`default_nettype none
package tpm_pkg;

    // Motor operating modes.
    typedef enum logic [1:0] {
        TPM_MM_TWO_SYM = 2'h0,
        TPM_MM_ONE_ASYM = 2'h1,
        TPM_MM_ONE_SYM = 2'h2,
        TPM_MM_SPARE = 2'h3
    } tpm_mmode_e;

    // Run control fields.
    typedef struct packed {
        logic [5:0] output_level_select;
        tpm_mmode_e motor_mode;
        logic motor_pulse_unit;
        logic updown;
        logic run_start_bit;
    } tpm_ctrl_s;

    // Dead-time configuration fields.
    typedef struct packed {
        logic dead_time_enable;
        logic dead_time_prescale_select;
        logic [7:0] dead_time_count;
    } tpm_dead_s;

    // One ADC trigger timing point.
    typedef struct packed {
        logic [1:0] trigger_match_select;
        logic [15:0] match;
    } tpm_trig_s;

endpackage
`default_nettype wire

//--- tpm_motor_pwm.sv
// Three-channel motor PWM generator with dead time, short protection and ADC triggers.
//
// Function
// - Three pairs, six outputs, independent normal channels.
// - Stopped: all outputs held low.
// - Running: counter counts up to period.
// - Normal mode: first period has no pulse.
// - Up mode: active until counter reaches duty.
// - Up/down period is 2 x period cycles; up is period + 1.
// - Pair opposite by default; polarity selectable.
// - Three motor modes; one-channel modes start with the low side high.
// - Two-channel symmetric: up sets, down clears.
// - Asymmetric: high duty sets, low duty clears.
// - One-channel symmetric: high duty sets, clears.
// - One-channel modes: low side inverts high.
// - Dead time on every change to active in one-channel modes.
// - Dead time is count times 4 or 16.
// - Duty match masks; counter end unmasks.
// - No dead time in two-channel symmetric.
// - Six triggers emit ADC start pulses.
// - Every timing event can request interrupt.
// - Both internal sides high forces both low.
// - Duty flags show trigger match when enabled.
// - Period flag set by event, write-one clears.
`timescale 1ns/100ps
`default_nettype none
`include "tpm_defines.svh"

module tpm_motor_pwm
    import tpm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [`TPM_ADDR_W-1:0] reg_addr_i,
    input wire logic [`TPM_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`TPM_DATA_W-1:0] reg_rdata_o,
    output logic [5:0] pwm_o,
    output logic [5:0] adc_soc_o,
    output logic irq_o
);

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    tpm_ctrl_s ctrl;
    tpm_dead_s dead;
    tpm_trig_s trig [6];
    logic [15:0] period_value;
    logic [15:0] duty [6];
    logic [7:0] status;
    logic [15:0] cnt;
    logic count_down;
    logic first_period;
    logic [5:0] mlvl;
    logic [2:0] dt_busy;
    logic [`TPM_DT_CYC_W-1:0] dt_cyc [3];

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // Writes to unmapped offsets match no decode and are dropped.
    wire logic wr_ctrl = reg_wr_i && (reg_addr_i == `TPM_OFS_CTRL);
    wire logic wr_period = reg_wr_i && (reg_addr_i == `TPM_OFS_PERIOD);
    wire logic wr_dead = reg_wr_i && (reg_addr_i == `TPM_OFS_DEAD);
    wire logic wr_status = reg_wr_i && (reg_addr_i == `TPM_OFS_STATUS);
    wire logic running = ctrl.run_start_bit;
    wire logic motor = ctrl.motor_pulse_unit;
    // Motor modes need the down slope, so they force up/down counting.
    wire logic updown_eff = ctrl.updown | motor;
    wire logic at_top = !count_down && (cnt >= period_value);
    wire logic at_bottom = count_down && (cnt == 16'h0000);
    wire logic period_evt = running && at_top;
    wire logic bottom_evt = running && at_bottom;
    wire logic period_end = updown_eff ? bottom_evt : period_evt;
    wire logic dt_allowed = motor && dead.dead_time_enable &&
                            (ctrl.motor_mode != TPM_MM_TWO_SYM);
    // Dead time in clock cycles, count scaled by 4 or 16.
    // dead time scaling
    wire logic [`TPM_DT_CYC_W-1:0] dt_target = dead.dead_time_prescale_select ?
        {dead.dead_time_count, 4'h0} : {2'h0, dead.dead_time_count, 2'h0};

    logic [5:0] up_match;
    logic [5:0] dn_match;
    logic [5:0] duty_evt;
    logic [5:0] trig_evt;
    logic [5:0] normal_lvl;
    logic [5:0] next_mlvl;
    logic [5:0] int_lvl;
    logic [5:0] safe_lvl;
    logic [5:0] wr_duty;
    logic [5:0] wr_trig;
    logic [`TPM_DATA_W-1:0] rd_duty [6];
    logic [`TPM_DATA_W-1:0] rd_trig [6];
    logic [2:0] h_change;

    // ------------------------------------------------------------------------
    // Per-output matches, normal levels and triggers
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_out
            localparam logic [7:0] OFS_D = `TPM_OFS_DUTY0 + 8'(gi * 4);
            localparam logic [7:0] OFS_T = `TPM_OFS_TRIG0 + 8'(gi * 4);
            assign wr_duty[gi] = reg_wr_i && (reg_addr_i == OFS_D);
            assign wr_trig[gi] = reg_wr_i && (reg_addr_i == OFS_T);
            assign rd_duty[gi] = (reg_addr_i == OFS_D) ? {16'h0000, duty[gi]} : 32'h0;
            assign rd_trig[gi] = (reg_addr_i == OFS_T) ?
                {14'h0000, trig[gi].trigger_match_select, trig[gi].match} : 32'h0;
            assign up_match[gi] = running && !count_down && (cnt == duty[gi]);
            assign dn_match[gi] = running && count_down && (cnt == duty[gi]);
            assign duty_evt[gi] = up_match[gi] | dn_match[gi];
            assign normal_lvl[gi] = running && !first_period && (cnt < duty[gi]);
            // Triggers ignore the first period, so conversions may start at once.
            // trigger match select
            assign trig_evt[gi] = running && (cnt == trig[gi].match) &&
                ((trig[gi].trigger_match_select[0] && !count_down) ||
                 (trig[gi].trigger_match_select[1] && count_down));
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Per-channel motor levels, dead time and short protection
    // ------------------------------------------------------------------------
    genvar gc;
    generate
        for (gc = 0; gc < 3; gc = gc + 1) begin : g_ch
            logic nh;
            logic nl;
            // Without a match on either slope, the present level is kept.
            always_comb begin
                nh = mlvl[gc];
                nl = mlvl[gc+3];
                unique case (ctrl.motor_mode)
                    TPM_MM_ONE_ASYM: begin
                        if (up_match[gc]) begin
                            nh = 1'b1;
                        end else if (dn_match[gc+3]) begin
                            nh = 1'b0;
                        end
                        nl = !nh;
                    end
                    TPM_MM_ONE_SYM, TPM_MM_SPARE: begin
                        if (up_match[gc]) begin
                            nh = 1'b1;
                        end else if (dn_match[gc]) begin
                            nh = 1'b0;
                        end
                        nl = !nh;
                    end
                    default: begin
                        if (up_match[gc]) begin
                            nh = 1'b1;
                        end else if (dn_match[gc]) begin
                            nh = 1'b0;
                        end
                        if (up_match[gc+3]) begin
                            nl = 1'b1;
                        end else if (dn_match[gc+3]) begin
                            nl = 1'b0;
                        end
                    end
                endcase
            end
            assign next_mlvl[gc] = running && motor && nh;
            assign next_mlvl[gc+3] = running && motor && nl;
            // Each high-side edge drives one side toward active, so each needs dead time.
            assign h_change[gc] = next_mlvl[gc] != mlvl[gc];

            // A change during a mask restarts it, so the last edge gets a full gap.
            // dead-time mask counter
            always_ff @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    dt_busy[gc] <= 1'b0;
                    dt_cyc[gc] <= '0;
                end else if (!dt_allowed || !running) begin
                    dt_busy[gc] <= 1'b0;
                    dt_cyc[gc] <= '0;
                end else if (h_change[gc]) begin
                    dt_busy[gc] <= (dt_target != '0);
                    dt_cyc[gc] <= '0;
                end else if (dt_busy[gc]) begin
                    dt_cyc[gc] <= dt_cyc[gc] + 1'b1;
                    dt_busy[gc] <= (dt_cyc[gc] + 1'b1) != dt_target;
                end
            end

            assign int_lvl[gc] = motor ? (mlvl[gc] && !(dt_busy[gc] && dt_allowed))
                                       : normal_lvl[gc];
            assign int_lvl[gc+3] = motor ? (mlvl[gc+3] && !(dt_busy[gc] && dt_allowed))
                                         : normal_lvl[gc+3];
            // Protection acts on internal levels, so inverted pins still turn off.
            // short protection
            assign safe_lvl[gc] = int_lvl[gc] && !int_lvl[gc+3];
            assign safe_lvl[gc+3] = int_lvl[gc+3] && !int_lvl[gc];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------------------
    // A zero period holds the counter at zero instead of wrapping.
    // count up then optionally down.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 16'h0000;
            count_down <= 1'b0;
        end else if (!running) begin
            cnt <= 16'h0000;
            count_down <= 1'b0;
        end else if (at_top) begin
            count_down <= updown_eff && (period_value != 16'h0000);
            cnt <= (updown_eff && period_value != 16'h0000) ? period_value - 16'h0001
                                                             : 16'h0000;
        end else if (at_bottom) begin
            count_down <= 1'b0;
            cnt <= (period_value != 16'h0000) ? 16'h0001 : 16'h0000;
        end else if (count_down) begin
            cnt <= cnt - 16'h0001;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            first_period <= 1'b1;
        end else if (!running) begin
            first_period <= 1'b1;
        end else if (period_end) begin
            first_period <= 1'b0;
        end
    end

    // Motor level state.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mlvl <= 6'h00;
        end else begin
            mlvl <= next_mlvl;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // The output register lags the counter by one cycle, two in motor modes; users must allow for it.
    // polarity then stop gating; registered to keep pins glitch free.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwm_o <= 6'h00;
            adc_soc_o <= 6'h00;
        end else begin
            pwm_o <= running ? (safe_lvl ^ ctrl.output_level_select) : 6'h00;
            adc_soc_o <= trig_evt;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= '{output_level_select: `TPM_OLS_RESET, motor_mode: TPM_MM_TWO_SYM,
                      motor_pulse_unit: 1'b0, updown: 1'b0, run_start_bit: 1'b0};
            dead <= '0;
            period_value <= `TPM_PERIOD_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl.run_start_bit <= reg_wdata_i[`TPM_CTRL_RUN];
                ctrl.updown <= reg_wdata_i[`TPM_CTRL_UPDOWN];
                ctrl.motor_pulse_unit <= reg_wdata_i[`TPM_CTRL_MOTOR];
                ctrl.motor_mode <= tpm_mmode_e'(
                    reg_wdata_i[`TPM_CTRL_MMODE_HI:`TPM_CTRL_MMODE_LO]);
                ctrl.output_level_select <= reg_wdata_i[`TPM_CTRL_OLS_HI:`TPM_CTRL_OLS_LO];
            end
            if (wr_dead) begin
                dead.dead_time_enable <= reg_wdata_i[`TPM_DEAD_EN];
                dead.dead_time_prescale_select <= reg_wdata_i[`TPM_DEAD_PRESC];
                dead.dead_time_count <= reg_wdata_i[`TPM_DEAD_CNT_HI:0];
            end
            // Period writes act at once; there is no shadow register.
            if (wr_period) begin
                period_value <= reg_wdata_i[15:0];
            end
        end
    end

    // Duty and trigger tables.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 6; i++) begin
                duty[i] <= 16'h0000;
                trig[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (wr_duty[i]) begin
                    duty[i] <= reg_wdata_i[15:0];
                end
                if (wr_trig[i]) begin
                    trig[i] <= reg_wdata_i[`TPM_TRIG_SEL_HI:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Event status
    // ------------------------------------------------------------------------
    logic [7:0] set_bits;
    always_comb begin
        set_bits = {period_evt, bottom_evt, 6'h00};
        for (int i = 0; i < 6; i++) begin
            set_bits[i] = (trig[i].trigger_match_select == 2'h0) ? duty_evt[i] : trig_evt[i];
        end
    end

    // Write-one-to-clear lets software acknowledge one event and keep others.
    // write one clears; a same-cycle event wins over the clear.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status <= 8'h00;
        end else begin
            status <= (status & ~(wr_status ? reg_wdata_i[7:0] : 8'h00)) | set_bits;
        end
    end

    // No mask: every flag raises the request, so unused flags must be cleared.
    // interrupt request
    assign irq_o = |status;

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    logic [`TPM_DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        // Table words are merged first; fixed registers override them below.
        for (int i = 0; i < 6; i++) begin
            rd_mux = rd_mux | rd_duty[i] | rd_trig[i];
        end
        unique case (reg_addr_i)
            `TPM_OFS_CTRL: rd_mux = {18'h0, ctrl.output_level_select, 3'h0,
                                     ctrl.motor_mode, ctrl.motor_pulse_unit,
                                     ctrl.updown, ctrl.run_start_bit};
            `TPM_OFS_PERIOD: rd_mux = {16'h0, period_value};
            `TPM_OFS_DEAD: rd_mux = {16'h0, dead.dead_time_enable, 6'h00,
                                     dead.dead_time_prescale_select, dead.dead_time_count};
            `TPM_OFS_STATUS: rd_mux = {16'h0, count_down, 7'h00, status};
            `TPM_OFS_COUNT: rd_mux = {16'h0, cnt};
            default: ;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
        end
    end

endmodule
`default_nettype wire

//--- tpm_motor_pwm_monitor.sv
// Concurrent checks on the ports of the motor PWM block.
`timescale 1ns/100ps
`default_nettype none
`include "tpm_defines.svh"

module tpm_motor_pwm_monitor (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [`TPM_ADDR_W-1:0] reg_addr_i,
    input wire logic [`TPM_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`TPM_DATA_W-1:0] reg_rdata_o,
    input wire logic [5:0] pwm_o,
    input wire logic [5:0] adc_soc_o,
    input wire logic irq_o
);
    default clocking mon_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    logic run_q;
    logic [5:0] ols_q;

    // Register decodes and the internal level seen through the polarity shadow.
    wire logic ctrl_wr = reg_wr_i && (reg_addr_i == `TPM_OFS_CTRL);
    wire logic st_wr = reg_wr_i && (reg_addr_i == `TPM_OFS_STATUS);
    wire logic cnt_rd = reg_rd_i && (reg_addr_i == `TPM_OFS_COUNT);
    wire logic [5:0] lvl = pwm_o ^ ols_q;

    // Shadow of run and polarity, so the checks need no view inside the block.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_q <= 1'b0;
            ols_q <= `TPM_OLS_RESET;
        end else if (ctrl_wr) begin
            run_q <= reg_wdata_i[`TPM_CTRL_RUN];
            ols_q <= reg_wdata_i[`TPM_CTRL_OLS_HI:`TPM_CTRL_OLS_LO];
        end
    end

    a_stop_low: assert property ((!run_q) [*3] |-> pwm_o == 6'h00)
        else $error("outputs active while stopped");
    a_count_cleared: assert property (cnt_rd && !run_q && !$past(run_q)
        |=> reg_rdata_o == 32'h0) else $error("counter not zero while stopped");
    a_pair_apart: assert property (run_q && $past(run_q) && $stable(ols_q)
        |-> (lvl[2:0] & lvl[5:3]) == 3'h0) else $error("both sides of a pair active");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside the read answer cycle");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i >= 8'h44 |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_soc_single: assert property ((adc_soc_o & $past(adc_soc_o)) == 6'h00)
        else $error("conversion start longer than one cycle");
    a_soc_running: assert property (|adc_soc_o
        |-> run_q || $past(run_q) || $past(run_q, 2)) else $error("conversion start when stopped");
    a_soc_flags_irq: assert property (|adc_soc_o |-> ##[0:1] irq_o)
        else $error("trigger match raised no request");
    a_irq_clear_cause: assert property ($fell(irq_o) |-> $past(st_wr))
        else $error("request dropped without a status write");
endmodule

bind tpm_motor_pwm tpm_motor_pwm_monitor mon (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pwm_o(pwm_o),
    .adc_soc_o(adc_soc_o), .irq_o(irq_o));
`default_nettype wire

//--- tpm_gate_model.sv
// Stand-in for the bridge gate drivers and the converter start input.
`timescale 1ns/100ps
`default_nettype none

module tpm_gate_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [5:0] gate_i,
    input wire logic [5:0] soc_i,
    output logic [15:0] hi_on_o,
    output logic [15:0] lo_on_o,
    output logic shoot_o,
    output logic [5:0][7:0] soc_cnt_o
);
    // Phase U conduction time, a sticky shoot-through flag and start counts.
    // It only samples at the edge, so a narrow glitch goes unseen; the checker also samples only at the edge.
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            hi_on_o <= 16'h0000;
            lo_on_o <= 16'h0000;
            shoot_o <= 1'b0;
            soc_cnt_o <= '0;
        end else begin
            hi_on_o <= hi_on_o + {15'h0000, gate_i[0]};
            lo_on_o <= lo_on_o + {15'h0000, gate_i[3]};
            shoot_o <= shoot_o | (|(gate_i[2:0] & gate_i[5:3]));
            for (int i = 0; i < 6; i++) begin
                soc_cnt_o[i] <= soc_cnt_o[i] + {7'h00, soc_i[i]};
            end
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the motor PWM: register sequences against expected waveforms.
`timescale 1ns/100ps
`default_nettype none
`include "tpm_defines.svh"

module tb;
    logic clk_sys_i;
    logic nrst_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic [5:0] pwm_o;
    logic [5:0] adc_soc_o;
    logic irq_o;
    logic clr;
    logic [15:0] hi_on;
    logic [15:0] lo_on;
    logic shoot;
    logic [5:0][7:0] soc_cnt;
    int errors = 0;
    int comparisons = 0;
    // Start counts per trigger in up and in up/down counting; selects run up, down, both.
    logic [7:0] soc_up [6] = '{8'h06, 8'h00, 8'h06, 8'h06, 8'h00, 8'h06};
    logic [7:0] soc_ud [6] = '{8'h04, 8'h04, 8'h08, 8'h04, 8'h04, 8'h08};
    // Motor rows: mode, dead-time word, low duty, expected high and low conduction.
    logic [1:0] mt_mm [6] = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0};
    logic [15:0] mt_dead [6] = '{16'h0, 16'h8002, 16'h8101, 16'h8002, 16'h0, 16'h0};
    logic [15:0] mt_d3 [6] = '{16'hc, 16'hc, 16'hc, 16'h15, 16'hc, 16'hc};
    logic [15:0] mt_hi [6] = '{16'h18, 16'h10, 16'h8, 16'h18, 16'h14, 16'h8};
    logic [15:0] mt_lo [6] = '{16'h10, 16'h8, 16'h0, 16'h0, 16'h14, 16'h0};

    tpm_motor_pwm uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pwm_o(pwm_o), .adc_soc_o(adc_soc_o), .irq_o(irq_o));
    tpm_gate_model gates (.clk_i(clk_sys_i), .clr_i(clr), .gate_i(pwm_o), .soc_i(adc_soc_o),
        .hi_on_o(hi_on), .lo_on_o(lo_on), .shoot_o(shoot), .soc_cnt_o(soc_cnt));

    // Comparison shared by every test; unknowns never match.
    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask

    // One-cycle write; a gap cycle follows so no strobe is driven twice in a step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    // One-cycle read; the answer is taken in the single cycle it stands.
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string n);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        check(n, reg_rdata_o & m, e);
    endtask

    // Clears the gate model, then lets it count for n cycles.
    task automatic window(input int n);
        @(posedge clk_sys_i);
        clr <= 1'b1;
        @(posedge clk_sys_i);
        clr <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Free-running system clock.
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Watchdog well beyond the roughly 820 cycles the tests need.
    initial begin
        repeat (6000) @(posedge clk_sys_i);
        errors++;
        $display("ERROR watchdog expected finish seen timeout");
        stop_test();
    end

    // Main sequence.
    initial begin
        nrst_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        clr = 1'b1;
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rd(`TPM_OFS_CTRL, 32'hffffffff, 32'h00003800, "ctrl");
        rd(`TPM_OFS_PERIOD, 32'hffffffff, 32'h0000ffff, "period");
        rd(`TPM_OFS_DEAD, 32'hffffffff, 32'h0, "dead");
        rd(8'h80, 32'hffffffff, 32'h0, "unmapped");
        check("pwm idle", {26'h0, pwm_o}, 32'h0);
        $display("test reset done");
        wr(`TPM_OFS_PERIOD, 32'h3);
        wr(`TPM_OFS_DUTY0, 32'h2);
        wr(`TPM_OFS_CTRL, 32'h3801);
        window(3);
        check("first period", {16'h0, hi_on}, 32'h0);
        window(8);
        check("normal high", {16'h0, hi_on}, 32'h4);
        check("normal low", {16'h0, lo_on}, 32'h8);
        $display("test normal done");
        for (int i = 0; i < 6; i++) begin
            wr(8'(`TPM_OFS_TRIG0 + 4 * i), {14'h0, 2'(i % 3 + 1), 16'h0001});
        end
        for (int m = 0; m < 2; m++) begin
            wr(`TPM_OFS_CTRL, 32'h3800);
            wr(`TPM_OFS_CTRL, 32'h3801 | 32'(m << 1));
            window(24);
            for (int i = 0; i < 6; i++) begin
                check("soc", {24'h0, soc_cnt[i]}, {24'h0, m ? soc_ud[i] : soc_up[i]});
            end
        end
        rd(`TPM_OFS_STATUS, 32'hff, 32'hff, "status set");
        check("irq set", {31'h0, irq_o}, 32'h1);
        wr(`TPM_OFS_CTRL, 32'h3800);
        wr(`TPM_OFS_STATUS, 32'h0);
        rd(`TPM_OFS_STATUS, 32'hff, 32'hff, "status kept");
        wr(`TPM_OFS_STATUS, 32'hff);
        rd(`TPM_OFS_STATUS, 32'hffffffff, 32'h0, "status clear");
        check("irq clear", {31'h0, irq_o}, 32'h0);
        rd(`TPM_OFS_COUNT, 32'hffffffff, 32'h0, "count stop");
        wr(`TPM_OFS_TRIG0, 32'h0);
        wr(`TPM_OFS_CTRL, 32'h3801);
        repeat (4) @(posedge clk_sys_i);
        rd(`TPM_OFS_STATUS, 32'h1, 32'h1, "duty flag");
        $display("test trigger done");
        wr(`TPM_OFS_PERIOD, 32'h14);
        wr(`TPM_OFS_DUTY0, 32'h8);
        for (int r = 0; r < 6; r++) begin
            wr(`TPM_OFS_CTRL, 32'h0);
            wr(`TPM_OFS_DEAD, {16'h0, mt_dead[r]});
            wr(`TPM_OFS_DUTY0 + 8'h0c, {16'h0, mt_d3[r]});
            wr(`TPM_OFS_CTRL, {27'h0, mt_mm[r], 3'h5});
            repeat (3) @(posedge clk_sys_i);
            #1;
            if (mt_mm[r] != 2'h0 && mt_dead[r] == 16'h0) begin
                check("start", {30'h0, pwm_o[3], pwm_o[0]}, 32'h2);
            end
            repeat (60) @(posedge clk_sys_i);
            window(40);
            check("motor high", {16'h0, hi_on}, {16'h0, mt_hi[r]});
            check("motor low", {16'h0, lo_on}, {16'h0, mt_lo[r]});
            check("shoot", {31'h0, shoot}, 32'h0);
        end
        $display("test motor done");
        stop_test();
    end
endmodule
`default_nettype wire
